// *** rtl/gacs_top.sv ***
// Global host access, channel steering, channel enables and pin sync control.
// Assumes a host on a strobed 8/16-bit microport and six channel blocks on MCLK_I.
//
// Function
// - Sync bit selects direct or resynchronised control
// - Access only when identity field matches pins
// - Width bit picks 8- or 16-bit transfers
// - Channel writes go to steered channels
// - Several steered channels get same data
// - Reads answer from lowest steered channel
// - Enable bit powers each channel's logic
// - Channel enables reset to zero
// - Start sync skips disabled channels
// - Global hop enable gates pin hops
// - Global start enable gates pin starts
// - First-only mode ignores later events
// - Edge bit picks rising edge or level
// - Per-pin enables; channels choose pin
`timescale 1ns/100ps
module gacs_top
    import gacs_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                                 MCLK_I,
    input  wire logic                                 RESETN_I,
    input  wire logic                                 CE_I,
    // Host microport
    input  wire logic                                 HOST_CS_N_I,
    input  wire logic                                 HOST_DATA_STROBE_N_I,
    input  wire logic                                 HOST_RW_I,
    input  wire logic [gacs_pkg::ADDR_W-1:0]          HOST_ADDR_I,
    input  wire logic [gacs_pkg::DATA_W-1:0]          HOST_DATA_I,
    output logic      [gacs_pkg::DATA_W-1:0]          HOST_DATA_O,
    output logic                                      HOST_DATA_OE_N_O,
    output logic                                      HOST_RDY_O,
    input  wire logic [gacs_pkg::ID_W-1:0]            PART_IDENTITY_PINS_I,
    // Channel register access
    output logic      [gacs_pkg::NUM_CH-1:0]          CH_WR_O,
    output logic      [1:0]                           CH_BE_O,
    output logic      [gacs_pkg::ADDR_W-1:0]          CH_ADDR_O,
    output logic      [gacs_pkg::DATA_W-1:0]          CH_WDATA_O,
    output logic      [gacs_pkg::NUM_CH-1:0]          CH_RD_SEL_O,
    input  wire logic [gacs_pkg::NUM_CH*gacs_pkg::DATA_W-1:0] CH_RDATA_I,
    // Channel enables and sync
    output logic      [gacs_pkg::NUM_CH-1:0]          CH_ENABLE_O,
    input  wire logic [gacs_pkg::NUM_CH-1:0]          CH_PIN_SYNC_I,
    input  wire logic [gacs_pkg::NUM_CH*gacs_pkg::PSEL_W-1:0] CH_PIN_SEL_I,
    input  wire logic [gacs_pkg::NUM_PIN-1:0]         EVENT_PIN_I,
    output logic      [gacs_pkg::NUM_CH-1:0]          HOP_SYNC_O,
    output logic      [gacs_pkg::NUM_CH-1:0]          START_SYNC_O
);
    import gacs_pkg::*;

    typedef struct packed {
        gacs_state_t         st;
        logic [7:0]          acc_ctl;
        logic [NUM_CH-1:0]   steer;
        logic [NUM_CH-1:0]   ch_en;
        logic [7:0]          pin_cfg;
        logic                ds_prev;
        logic                first_seen;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   rdata;
        logic                oe_n;
        logic                rdy;
        logic [NUM_CH-1:0]   ch_wr;
        logic [1:0]          ch_be;
        logic [NUM_CH-1:0]   rd_sel;
        logic [NUM_CH-1:0]   hop;
        logic [NUM_CH-1:0]   start;
    } gacs_top_st_t;

    gacs_top_st_t s_q;
    gacs_top_st_t s_d;

    logic [2:0]         ctl_sync;
    logic [ID_W-1:0]    id_sync;
    logic [NUM_PIN-1:0] pin_sync;
    logic [NUM_PIN-1:0] pin_evt;

    // Lowest set bit as one-hot
    function automatic logic [NUM_CH-1:0] lowest_one(input logic [NUM_CH-1:0] v);
        logic [NUM_CH-1:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // Readback of one global register byte
    function automatic logic [7:0] glob_byte(input gacs_top_st_t s, input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            ADDR_HOST_ACC: r = s.acc_ctl & ACC_RW_MASK;
            ADDR_CH_STEER: r = {2'b00, s.steer};
            ADDR_CH_PWR:   r = {2'b00, s.ch_en};
            ADDR_PIN_SYNC: r = s.pin_cfg;
            default:       r = 8'h00;
        endcase
        return r;
    endfunction

    // async control resync
    // Carried inverted so reset leaves select and strobe idle, no false take
    gacs_event_pin_two #(
        .W(3)
    ) u_ctl_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .async_i (~{HOST_CS_N_I, HOST_DATA_STROBE_N_I, HOST_RW_I}),
        .sync_o  (ctl_sync)
    );

    // Identity straps are pins, so they are synchronised too
    gacs_event_pin_two #(
        .W(ID_W)
    ) u_id_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .async_i (PART_IDENTITY_PINS_I),
        .sync_o  (id_sync)
    );

    gacs_event_pin_two #(
        .W(NUM_PIN)
    ) u_pin_sync (
        .clk_i   (MCLK_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .async_i (EVENT_PIN_I),
        .sync_o  (pin_sync)
    );

    // One detector per event pin
    for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
        gacs_evt_det u_det (
            .clk_i       (MCLK_I),
            .rst_n_i     (RESETN_I),
            .ce_i        (CE_I),
            .en_i        (s_q.pin_cfg[PS_PIN_LSB + p]),
            .edge_mode_i (s_q.pin_cfg[PS_EDGE_BIT]),
            .level_i     (pin_sync[p]),
            .evt_o       (pin_evt[p])
        );
    end

    // Next-state logic
    always_comb begin
        logic                cs_n;
        logic                ds_n;
        logic                rd;
        logic                wide;
        logic                id_ok;
        logic                in_ch;
        logic                pass;
        logic [7:0]          a;
        logic [7:0]          b;
        logic [NUM_CH-1:0]   raw;
        logic [NUM_CH-1:0]   lo;
        logic [PSEL_W-1:0]   sel;
        logic [DATA_W-1:0]   chd;
        cs_n  = 1'b1;
        ds_n  = 1'b1;
        rd    = 1'b0;
        wide  = 1'b0;
        id_ok = 1'b0;
        in_ch = 1'b0;
        pass  = 1'b0;
        a     = 8'h00;
        b     = 8'h00;
        raw   = '0;
        lo    = '0;
        sel   = '0;
        chd   = '0;
        s_d   = s_q;

        if (s_q.acc_ctl[ACC_SYNC_BIT]) begin
            cs_n = HOST_CS_N_I;
            ds_n = HOST_DATA_STROBE_N_I;
            rd   = HOST_RW_I;
        end else begin
            cs_n = ~ctl_sync[2];
            ds_n = ~ctl_sync[1];
            rd   = ~ctl_sync[0];
        end
        wide  = s_q.acc_ctl[ACC_WIDE_BIT];
        id_ok = (s_q.acc_ctl[ACC_ID_LSB +: ID_W] == id_sync);
        in_ch = (HOST_ADDR_I >= ADDR_CH_LO) && (HOST_ADDR_I <= ADDR_CH_HI);
        lo    = lowest_one(s_q.steer);
        for (int c = 0; c < NUM_CH; c++) begin
            if (lo[c]) begin
                chd = CH_RDATA_I[c*DATA_W +: DATA_W];
            end
        end

        // Per-channel sync candidates
        for (int c = 0; c < NUM_CH; c++) begin
            sel = CH_PIN_SEL_I[c*PSEL_W +: PSEL_W];
            raw[c] = CH_PIN_SYNC_I[c] & pin_evt[sel] & s_q.ch_en[c];
        end

        if (CE_I) begin
            s_d.ds_prev = ds_n;
            s_d.ch_wr   = '0;

            pass = ~(s_q.pin_cfg[PS_FIRST_BIT] & s_q.first_seen);
            if (!s_q.pin_cfg[PS_FIRST_BIT]) begin
                s_d.first_seen = 1'b0;
            end else if (|raw) begin
                s_d.first_seen = 1'b1;
            end
            s_d.hop   = raw & {NUM_CH{s_q.pin_cfg[PS_HOP_BIT] & pass}};
            s_d.start = raw & {NUM_CH{s_q.pin_cfg[PS_START_BIT] & pass}};

            case (s_q.st)
                GACS_IDLE: begin
                    // Strobe falling edge opens an access
                    // ignore foreign accesses
                    if (s_q.ds_prev && !ds_n && !cs_n && id_ok) begin
                        s_d.addr  = HOST_ADDR_I;
                        s_d.wdata = wide ? HOST_DATA_I : {8'h00, HOST_DATA_I[7:0]};
                        s_d.ch_be = wide ? BE_BOTH : BE_LOW;
                        if (in_ch) begin
                            if (rd) begin
                                s_d.rd_sel = lo;
                                s_d.st     = GACS_CAPT;
                            end else begin
                                s_d.ch_wr = s_q.steer;
                                s_d.rdy   = 1'b1;
                                s_d.st    = GACS_DRIVE;
                            end
                        end else if (rd) begin
                            s_d.rdata[7:0]  = glob_byte(s_q, HOST_ADDR_I);
                            s_d.rdata[15:8] = wide ? glob_byte(s_q, HOST_ADDR_I + 8'h01)
                                                   : 8'h00;
                            s_d.oe_n = 1'b0;
                            s_d.rdy  = 1'b1;
                            s_d.st   = GACS_DRIVE;
                        end else begin
                            for (int k = 0; k < 2; k++) begin
                                a = HOST_ADDR_I + 8'(k);
                                b = HOST_DATA_I[k*8 +: 8];
                                if (k == 0 || wide) begin
                                    case (a)
                                        ADDR_HOST_ACC: s_d.acc_ctl = b & ACC_RW_MASK;
                                        ADDR_CH_PWR:   s_d.ch_en   = b[NUM_CH-1:0];
                                        ADDR_CH_STEER: s_d.steer   = b[NUM_CH-1:0];
                                        ADDR_PIN_SYNC: s_d.pin_cfg = b;
                                        default:       s_d.pin_cfg = s_d.pin_cfg;
                                    endcase
                                end
                            end
                            s_d.rdy = 1'b1;
                            s_d.st  = GACS_DRIVE;
                        end
                    end
                end
                GACS_CAPT: begin
                    // Channel answered with one cycle of latency
                    // lowest channel data
                    s_d.rdata = wide ? chd : {8'h00, chd[7:0]};
                    s_d.oe_n  = 1'b0;
                    s_d.rdy   = 1'b1;
                    s_d.st    = GACS_DRIVE;
                end
                GACS_DRIVE: begin
                    // Hold data until the host lets go of the strobe
                    if (ds_n) begin
                        s_d.oe_n   = 1'b1;
                        s_d.rdy    = 1'b0;
                        s_d.rd_sel = '0;
                        s_d.st     = GACS_IDLE;
                    end
                end
                default: begin
                    s_d.st   = GACS_IDLE;
                    s_d.oe_n = 1'b1;
                    s_d.rdy  = 1'b0;
                end
            endcase
        end
    end

    // State register; CE_I low holds everything
    // enables reset off
    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_q         <= '0;
            s_q.st      <= GACS_IDLE;
            s_q.acc_ctl <= RST_HOST_ACC;
            s_q.steer   <= RST_CH_STEER;
            s_q.ch_en   <= RST_CH_PWR;
            s_q.pin_cfg <= RST_PIN_SYNC;
            s_q.ds_prev <= 1'b1;
            s_q.oe_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign HOST_DATA_O      = s_q.rdata;
    assign HOST_DATA_OE_N_O = s_q.oe_n;
    assign HOST_RDY_O       = s_q.rdy;
    assign CH_WR_O          = s_q.ch_wr;
    assign CH_BE_O          = s_q.ch_be;
    assign CH_ADDR_O        = s_q.addr;
    assign CH_WDATA_O       = s_q.wdata;
    assign CH_RD_SEL_O      = s_q.rd_sel;
    assign CH_ENABLE_O      = s_q.ch_en;
    assign HOP_SYNC_O       = s_q.hop;
    assign START_SYNC_O     = s_q.start;
endmodule

// *** rtl/gacs_pkg.sv ***
// Shared constants for the global access and sync control block.
// Assumes a byte-addressed host microport and six channels, four event pins.
package gacs_pkg;
    // Sizes
    localparam int unsigned NUM_CH   = 6;
    localparam int unsigned NUM_PIN  = 4;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned ID_W     = 4;
    localparam int unsigned PSEL_W   = 2;

    // Global register byte addresses
    localparam logic [7:0] ADDR_HOST_ACC  = 8'h01;
    localparam logic [7:0] ADDR_CH_STEER  = 8'h02;
    localparam logic [7:0] ADDR_CH_PWR    = 8'h03;
    localparam logic [7:0] ADDR_PIN_SYNC  = 8'h04;

    // Channel register space bounds
    localparam logic [7:0] ADDR_CH_LO     = 8'h68;
    localparam logic [7:0] ADDR_CH_HI     = 8'hBB;

    // Host port access control fields
    localparam int unsigned ACC_SYNC_BIT  = 7;
    localparam int unsigned ACC_ID_LSB    = 2;
    localparam int unsigned ACC_WIDE_BIT  = 0;
    localparam logic [7:0]  ACC_RW_MASK   = 8'hBD;

    // Pin sync configuration fields
    localparam int unsigned PS_HOP_BIT    = 7;
    localparam int unsigned PS_START_BIT  = 6;
    localparam int unsigned PS_FIRST_BIT  = 5;
    localparam int unsigned PS_EDGE_BIT   = 4;
    localparam int unsigned PS_PIN_LSB    = 0;

    // Reset values
    localparam logic [7:0] RST_HOST_ACC   = 8'h00;
    localparam logic [5:0] RST_CH_STEER   = 6'h00;
    localparam logic [5:0] RST_CH_PWR     = 6'h00;
    localparam logic [7:0] RST_PIN_SYNC   = 8'h00;

    // Byte enables toward channel registers
    localparam logic [1:0] BE_LOW         = 2'b01;
    localparam logic [1:0] BE_BOTH        = 2'b11;

    // Host access sequence; IDLE to CAPT to DRIVE changes one bit per step, DRIVE to IDLE changes two
    typedef enum logic [1:0] {
        GACS_IDLE  = 2'b00,
        GACS_CAPT  = 2'b01,
        GACS_DRIVE = 2'b11
    } gacs_state_t;
endpackage

// *** rtl/gacs_event_pin_two.sv ***
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes inputs change slowly against the 5 ns clock.
`timescale 1ns/100ps
module gacs_event_pin_two #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } gacs_sync_st_t;

    gacs_sync_st_t s_q;
    gacs_sync_st_t s_d;

    // First stage feeds only the second
    always_comb begin
        s_d = s_q;
        if (ce_i) begin
            s_d.meta = async_i;
            s_d.stab = s_q.meta;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.stab;
endmodule

// *** rtl/gacs_evt_det.sv ***
// Event detector for one synchronised event pin: edge or level mode.
// Assumes its level input is already synchronised to the clock.
`timescale 1ns/100ps
module gacs_evt_det (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    // Control
    input  wire logic en_i,
    input  wire logic edge_mode_i,
    // Pin and event
    input  wire logic level_i,
    output logic      evt_o
);
    typedef struct packed {
        logic prev;
    } gacs_evt_st_t;

    gacs_evt_st_t s_q;
    gacs_evt_st_t s_d;

    // Previous level kept for rising-edge detection
    always_comb begin
        s_d = s_q;
        if (ce_i) begin
            s_d.prev = level_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign evt_o = ce_i & en_i & level_i & (~edge_mode_i | ~s_q.prev);
endmodule

// *** verif/gacs_asserts.sv ***
// Port-level checker for gacs_top.
// Assumes the host holds strobe low until ready; bound to every gacs_top.
`timescale 1ns/100ps
module gacs_asserts
    import gacs_pkg::*;
(
    // Clock and reset
    input wire logic                              MCLK_I,
    input wire logic                              RESETN_I,
    // Host side
    input wire logic                              HOST_DATA_STROBE_N_I,
    input wire logic                              HOST_RDY_O,
    input wire logic                              HOST_DATA_OE_N_O,
    // Channel side
    input wire logic [gacs_pkg::NUM_CH-1:0]       CH_WR_O,
    input wire logic [gacs_pkg::NUM_CH-1:0]       CH_RD_SEL_O,
    input wire logic [gacs_pkg::NUM_CH-1:0]       CH_ENABLE_O,
    input wire logic [gacs_pkg::NUM_CH-1:0]       CH_PIN_SYNC_I,
    input wire logic [gacs_pkg::NUM_CH-1:0]       HOP_SYNC_O,
    input wire logic [gacs_pkg::NUM_CH-1:0]       START_SYNC_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);

    // Access steps: strobe held idle, ready raised
    sequence strobe_idle;
        HOST_DATA_STROBE_N_I [*5];
    endsequence
    sequence rdy_rise;
        $rose(HOST_RDY_O);
    endsequence

    a_rdy_needs_strobe: assert property (rdy_rise |-> !HOST_DATA_STROBE_N_I)
        else $error("ready rose without strobe");
    a_rdy_release: assert property (strobe_idle |-> !HOST_RDY_O)
        else $error("ready stuck after strobe release");
    a_wr_one_cycle: assert property (|CH_WR_O |=> CH_WR_O == '0)
        else $error("channel write longer than one cycle");
    a_wr_with_rdy: assert property (|CH_WR_O |-> ##[0:2] HOST_RDY_O)
        else $error("channel write without ready");
    a_rd_one_hot: assert property ($onehot0(CH_RD_SEL_O))
        else $error("read select not one-hot");
    a_oe_with_rdy: assert property (!HOST_DATA_OE_N_O |-> HOST_RDY_O)
        else $error("data driven without ready");
    a_hop_enabled: assert property (|HOP_SYNC_O |-> (HOP_SYNC_O & ~$past(CH_ENABLE_O)) == '0)
        else $error("hop on disabled channel");
    a_start_enabled: assert property (|START_SYNC_O |-> (START_SYNC_O & ~$past(CH_ENABLE_O)) == '0)
        else $error("start on disabled channel");
    a_hop_pin_sync: assert property (|HOP_SYNC_O |-> (HOP_SYNC_O & ~$past(CH_PIN_SYNC_I)) == '0)
        else $error("hop on channel not using pins");
endmodule

bind gacs_top gacs_asserts i_asserts (
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .HOST_DATA_STROBE_N_I(HOST_DATA_STROBE_N_I),
    .HOST_RDY_O(HOST_RDY_O), .HOST_DATA_OE_N_O(HOST_DATA_OE_N_O), .CH_WR_O(CH_WR_O),
    .CH_RD_SEL_O(CH_RD_SEL_O), .CH_ENABLE_O(CH_ENABLE_O), .CH_PIN_SYNC_I(CH_PIN_SYNC_I),
    .HOP_SYNC_O(HOP_SYNC_O), .START_SYNC_O(START_SYNC_O)
);

// *** verif/gacs_ch_model.sv ***
// Behavioural model of the six channel register banks.
// Assumes writes are one-cycle pulses; unselected banks drive inverted data.
`timescale 1ns/100ps
module gacs_ch_model
    import gacs_pkg::*;
(
    input  wire logic                          clk_i,
    input  wire logic [gacs_pkg::NUM_CH-1:0]   wr_i,
    input  wire logic [1:0]                    be_i,
    input  wire logic [7:0]                    addr_i,
    input  wire logic [15:0]                   wdata_i,
    input  wire logic [gacs_pkg::NUM_CH-1:0]   rd_sel_i,
    output logic      [6*16-1:0]               rdata_o
);
    import gacs_pkg::*;
    logic [15:0] mem [6][256];

    always @(posedge clk_i) begin
        for (int c = 0; c < 6; c++) begin
            if (wr_i[c] && be_i[0]) mem[c][addr_i][7:0] <= wdata_i[7:0];
            if (wr_i[c] && be_i[1]) mem[c][addr_i][15:8] <= wdata_i[15:8];
        end
    end

    // Not selected: inverse, so a stale value never passes
    always_comb begin
        for (int c = 0; c < 6; c++) begin
            rdata_o[16*c+:16] = rd_sel_i[c] ? mem[c][addr_i] : ~mem[c][addr_i];
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for gacs_top: host port tasks, channel model, pins.
// Assumes a 200 MHz clock and event pins toggled with a 70 ns period.
`timescale 1ns/100ps
module tb_top;
    import gacs_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic        cs_n = 1'b1;
    logic        ds_n = 1'b1;
    logic        rw = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic        oe_n;
    logic        rdy;
    logic [3:0]  ids = 4'h0;
    logic [5:0]  ch_wr, rd_sel, ch_en, hop, start;
    logic [1:0]  be;
    logic [7:0]  ch_addr;
    logic [15:0] ch_wd;
    logic [95:0] ch_rd;
    logic [5:0]  psync = 6'b00_0111;
    logic [11:0] psel = 12'h004;
    logic [3:0]  pins = 4'h0;
    logic        ok;
    logic [15:0] q;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          hop_cnt[6] = '{default: 0};
    int          st_cnt[6] = '{default: 0};
    logic [7:0]  cfg[6] = '{8'hD1, 8'h51, 8'h91, 8'hD0, 8'hC1, 8'hF1};
    int          eh[6] = '{2, 0, 2, 0, 12, 1};
    int          es[6] = '{2, 2, 0, 0, 12, 1};

    always #2.5 clk = ~clk;

    gacs_top i_dut (
        .MCLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .HOST_CS_N_I(cs_n),
        .HOST_DATA_STROBE_N_I(ds_n), .HOST_RW_I(rw), .HOST_ADDR_I(addr),
        .HOST_DATA_I(wdata), .HOST_DATA_O(rdata), .HOST_DATA_OE_N_O(oe_n),
        .HOST_RDY_O(rdy), .PART_IDENTITY_PINS_I(ids), .CH_WR_O(ch_wr), .CH_BE_O(be),
        .CH_ADDR_O(ch_addr), .CH_WDATA_O(ch_wd), .CH_RD_SEL_O(rd_sel), .CH_RDATA_I(ch_rd),
        .CH_ENABLE_O(ch_en), .CH_PIN_SYNC_I(psync), .CH_PIN_SEL_I(psel),
        .EVENT_PIN_I(pins), .HOP_SYNC_O(hop), .START_SYNC_O(start)
    );

    gacs_ch_model i_ch (
        .clk_i(clk), .wr_i(ch_wr), .be_i(be), .addr_i(ch_addr), .wdata_i(ch_wd),
        .rd_sel_i(rd_sel), .rdata_o(ch_rd)
    );

    // Pulse counters per channel
    always @(posedge clk) begin
        for (int c = 0; c < 6; c++) begin
            hop_cnt[c] += (hop[c] === 1'b1);
            st_cnt[c] += (start[c] === 1'b1);
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // One host access; held until ready, released after
    task automatic acc(input logic r, input logic [7:0] a, input logic [15:0] d);
        int n;
        ok = 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        ds_n <= 1'b0;
        rw <= r;
        addr <= a;
        wdata <= d;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            ok = (rdy === 1'b1);
            q = rdata;
            if (ok && r) chk({15'h0, oe_n}, 16'h0000);
        end
        cs_n <= 1'b1;
        ds_n <= 1'b1;
        for (n = 0; n < 20 && rdy !== 1'b0; n++) @(posedge clk);
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        acc(1'b0, a, d);
        chk({15'h0, ok}, 16'h0001);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        acc(1'b1, a, 16'h0000);
        chk({15'h0, ok}, 16'h0001);
        chk(q, exp);
    endtask

    // Two edges on pin zero, then let the pipeline drain
    task automatic pulse2();
        repeat (2) begin
            @(posedge clk) pins[0] <= 1'b1;
            repeat (6) @(posedge clk);
            pins[0] <= 1'b0;
            repeat (7) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        test_done();
    end

    initial begin
        int h0, s0, o0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 1; a < 5; a++) rd(8'(a), 16'h0000);
        chk({10'h0, ch_en}, 16'h0000);
        rd(8'h30, 16'h0000);
        $display("test 1 done");
        wr(8'h01, 16'hAAC3);
        rd(8'h01, 16'h0081);
        $display("test 2 done");
        wr(8'h01, 16'h0095);
        acc(1'b0, 8'h02, 16'h3F00);
        chk({15'h0, ok}, 16'h0000);
        ids <= 4'h5;
        repeat (4) @(posedge clk);
        rd(8'h02, 16'h0000);
        $display("test 3 done");
        wr(8'h02, 16'h0004);
        wr(8'h70, 16'hBEEF);
        wr(8'h02, 16'h0010);
        wr(8'h70, 16'h1234);
        wr(8'h02, 16'h0014);
        rd(8'h70, 16'hBEEF);
        wr(8'h74, 16'h5A5A);
        chk(i_ch.mem[2][8'h74], 16'h5A5A);
        chk(i_ch.mem[4][8'h74], 16'h5A5A);
        wr(8'h02, 16'h0000);
        rd(8'h70, 16'h0000);
        $display("test 4 done");
        wr(8'h02, 16'h0300);
        chk({10'h0, ch_en}, 16'h0003);
        for (int i = 0; i < 6; i++) begin
            wr(8'h04, {8'h00, cfg[i]});
            h0 = hop_cnt[0];
            s0 = st_cnt[0];
            o0 = hop_cnt[1] + hop_cnt[2] + st_cnt[1] + st_cnt[2];
            pulse2();
            chk(16'(hop_cnt[0] - h0), 16'(eh[i]));
            chk(16'(st_cnt[0] - s0), 16'(es[i]));
            chk(16'(hop_cnt[1] + hop_cnt[2] + st_cnt[1] + st_cnt[2] - o0), 16'h0000);
        end
        // Clock enable low: pin pulses must leave no trace
        wr(8'h04, 16'h00D1);
        h0 = hop_cnt[0] + st_cnt[0];
        ce <= 1'b0;
        pulse2();
        ce <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(hop_cnt[0] + st_cnt[0] - h0), 16'h0000);
        $display("test 5 done");
        test_done();
    end
endmodule
